// *** rtl/sg_dma_channel_regs.sv ***
// per-channel control/status registers and descriptor engines of the dma block
`timescale 1ns/1ps
`default_nettype none
module sg_dma_channel_regs
  import sg_dma_pkg::*;
#(
  parameter int SEC_CYCLES = sg_dma_pkg::ONE_SEC_CYCLES,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                                    sys_clk,
  input  wire logic                                    rst_n,
  input  wire logic                                    bar_valid,
  input  wire sg_dma_pkg::bar_req_t                    bar_req,
  output logic                                         bar_ready,
  output logic                                         bar_rvalid,
  output logic [31:0]                                  bar_rdata,
  output sg_dma_pkg::region_t                          bar_region,
  output logic [sg_dma_pkg::NUM_CHAN-1:0]              fetch_req,
  output logic [sg_dma_pkg::NUM_CHAN-1:0][31:0]        fetch_addr,
  input  wire logic [sg_dma_pkg::NUM_CHAN-1:0]         fetch_done,
  input  wire sg_dma_pkg::desc_resp_t [sg_dma_pkg::NUM_CHAN-1:0] fetch_resp,
  input  wire logic                                    in_valid,
  output logic                                         in_ready,
  input  wire sg_dma_pkg::beat_t                       in_beat,
  output logic                                         out_valid,
  input  wire logic                                    out_ready,
  output sg_dma_pkg::beat_t                            out_beat,
  output logic [sg_dma_pkg::NUM_CHAN-1:0]              irq,
  output logic [sg_dma_pkg::NUM_CHAN-1:0]              reset_request,
  input  wire logic [sg_dma_pkg::NUM_CHAN-1:0]         reset_ack,
  output logic [sg_dma_pkg::NUM_CHAN-1:0]              user_reset
);
  import sg_dma_pkg::*;

  localparam int SEC_W = $clog2(SEC_CYCLES);

  logic [NUM_CHAN-1:0]        wr_ctrl;
  logic [NUM_CHAN-1:0]        wr_ndp;
  logic [NUM_CHAN-1:0]        wr_sdp;
  logic [NUM_CHAN-1:0]        chan_hit;
  logic [NUM_CHAN-1:0]        ie_reg;
  logic [NUM_CHAN-1:0]        en_reg;
  logic [NUM_CHAN-1:0]        rreq_reg;
  logic [NUM_CHAN-1:0]        rst_reg;
  logic [NUM_CHAN-1:0][5:1]   flag_reg;
  logic [NUM_CHAN-1:0][5:1]   flag_set;
  logic [NUM_CHAN-1:0][31:PTR_LSB] ndp_reg;
  logic [NUM_CHAN-1:0][31:PTR_LSB] sdp_reg;
  logic [NUM_CHAN-1:0][31:0]  ctrl_word;
  logic [NUM_CHAN-1:0][31:0]  bytes_word;
  eng_state_t                 state_reg [NUM_CHAN];
  logic [NUM_CHAN-1:0][15:0]  beats_left_reg;
  logic [NUM_CHAN-1:0][31:PTR_LSB] pend_next_reg;
  logic [NUM_CHAN-1:0]        pend_ioc_reg;
  logic [NUM_CHAN-1:0]        beat_seen;
  logic [NUM_CHAN-1:0][31:CNT_LSB] accum_reg;
  logic [NUM_CHAN-1:0][31:CNT_LSB] bytes_reg;
  logic [NUM_CHAN-1:0][1:0]   sample_reg;
  logic [SEC_W-1:0]           sec_cnt_reg;
  logic                       sec_tick;
  logic [31:0]                rdata_next;
  region_t                    region_next;
  logic [7:0]                 reg_off;
  logic                       wr_go;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  assign bar_ready = 1'b1;
  assign reg_off   = bar_req.addr[7:0];
  assign wr_go     = bar_valid & bar_req.we;

  always_comb
  begin
    region_next = RG_NONE;
    if (chan_hit != '0)
    begin
      region_next = RG_CHAN;
    end
    else if (bar_req.addr[15:8] == COMMON_BASE[15:8])
    begin
      region_next = RG_COMMON;
    end
    else if (bar_req.addr[15:8] == PERF_BASE[15:8])
    begin
      region_next = RG_PERF;
    end
    else if (bar_req.addr[15:8] == APP0_BASE[15:8])
    begin
      region_next = RG_APP0;
    end
    else if (bar_req.addr[15:8] == APP1_BASE[15:8])
    begin
      region_next = RG_APP1;
    end
    else if (bar_req.addr[15:8] == PFIFO_BASE[15:8])
    begin
      region_next = RG_PFIFO;
    end
  end

  // only the channel windows are served here; other groups read zero
  always_comb
  begin
    rdata_next = REG_RESET;
    for (int i = 0; i < NUM_CHAN; i++)
    begin
      if (chan_hit[i])
      begin
        case (reg_off)
          OFF_CTRL:  rdata_next = ctrl_word[i];
          OFF_NDP:   rdata_next = {ndp_reg[i], 5'b0_0000};
          OFF_SDP:   rdata_next = {sdp_reg[i], 5'b0_0000};
          OFF_BYTES: rdata_next = bytes_word[i];
          default:   rdata_next = REG_RESET;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bar_rvalid <= 1'b0;
      bar_rdata  <= REG_RESET;
      bar_region <= RG_NONE;
    end
    else
    begin
      bar_rvalid <= bar_valid & ~bar_req.we;
      bar_rdata  <= (bar_valid & ~bar_req.we) ? rdata_next : REG_RESET;
      bar_region <= bar_valid ? region_next : RG_NONE;
    end
  end

  // ------------------------------------------------------------
  // one-second sample tick
  // ------------------------------------------------------------
  assign sec_tick = (sec_cnt_reg == SEC_W'(SEC_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sec_cnt_reg <= '0;
    end
    else
    begin
      sec_cnt_reg <= sec_tick ? '0 : sec_cnt_reg + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // data path fifo
  // ------------------------------------------------------------
  stream_fifo #(
    .WIDTH ($bits(beat_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_beat),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_beat)
  );

  // ------------------------------------------------------------
  // per-channel registers and engine
  // ------------------------------------------------------------
  for (genvar i = 0; i < NUM_CHAN; i++)
  begin : g_chan
    logic fetch_ok_aligned;

    assign chan_hit[i] = bar_req.addr[15:8] == CHAN_BASE[i][15:8];
    assign wr_ctrl[i]  = wr_go & chan_hit[i] & (reg_off == OFF_CTRL);
    assign wr_ndp[i]   = wr_go & chan_hit[i] & (reg_off == OFF_NDP);
    assign wr_sdp[i]   = wr_go & chan_hit[i] & (reg_off == OFF_SDP);
    assign beat_seen[i] = out_valid & out_ready & (out_beat.chan == CHAN_W'(i))
                          & (state_reg[i] == ST_XFER);
    assign fetch_ok_aligned = fetch_resp[i].next_ptr[PTR_LSB-1:0] == '0;

    // unused positions stay zero
    always_comb
    begin
      ctrl_word[i]         = REG_RESET;
      ctrl_word[i][B_IE]   = ie_reg[i];
      ctrl_word[i][B_IACT] = flag_reg[i][B_IACT];
      ctrl_word[i][B_DCMP] = flag_reg[i][B_DCMP];
      ctrl_word[i][B_ALGN] = flag_reg[i][B_ALGN];
      ctrl_word[i][B_FERR] = flag_reg[i][B_FERR];
      ctrl_word[i][B_SWAB] = flag_reg[i][B_SWAB];
      ctrl_word[i][B_EN]   = en_reg[i];
      ctrl_word[i][B_RUN]  = (state_reg[i] == ST_FETCH) | (state_reg[i] == ST_XFER);
      ctrl_word[i][B_WAIT] = state_reg[i] == ST_WAIT;
      ctrl_word[i][B_RREQ] = rreq_reg[i];
      ctrl_word[i][B_RST]  = rst_reg[i];
    end

    assign bytes_word[i]    = {bytes_reg[i], sample_reg[i]};
    assign irq[i]           = ie_reg[i] & flag_reg[i][B_IACT];
    assign reset_request[i] = rreq_reg[i];
    assign user_reset[i]    = rst_reg[i];
    assign fetch_req[i]     = state_reg[i] == ST_FETCH;
    assign fetch_addr[i]    = {ndp_reg[i], 5'b0_0000};

    always_comb
    begin
      flag_set[i] = '0;
      if (state_reg[i] == ST_FETCH && en_reg[i] && !rst_reg[i] && fetch_done[i])
      begin
        flag_set[i][B_FERR] = ~fetch_resp[i].ok;
        flag_set[i][B_ALGN] = fetch_resp[i].ok & ~fetch_ok_aligned;
      end
      if (state_reg[i] == ST_XFER && en_reg[i] && !rst_reg[i] && beats_left_reg[i] == '0)
      begin
        flag_set[i][B_DCMP] = pend_ioc_reg[i];
      end
      if (!en_reg[i] && !rst_reg[i]
          && (state_reg[i] == ST_FETCH || state_reg[i] == ST_XFER))
      begin
        flag_set[i][B_SWAB] = 1'b1;
      end
      flag_set[i][B_IACT] = |flag_set[i][5:2];
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        ie_reg[i]   <= 1'b0;
        en_reg[i]   <= 1'b0;
        rst_reg[i]  <= 1'b0;
        flag_reg[i] <= '0;
      end
      else
      begin
        if (wr_ctrl[i])
        begin
          ie_reg[i]  <= bar_req.wdata[B_IE];
          en_reg[i]  <= bar_req.wdata[B_EN];
          rst_reg[i] <= bar_req.wdata[B_RST];
        end
        // hardware set wins over a same-cycle clear
        flag_reg[i] <= (flag_reg[i] & ~(wr_ctrl[i] ? bar_req.wdata[5:1] : 5'b0_0000))
                       | flag_set[i];
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        rreq_reg[i] <= 1'b0;
      end
      else if (wr_ctrl[i] && bar_req.wdata[B_RREQ])
      begin
        rreq_reg[i] <= 1'b1;
      end
      else if (reset_ack[i])
      begin
        rreq_reg[i] <= 1'b0;
      end
      else if (wr_ctrl[i])
      begin
        rreq_reg[i] <= 1'b0;
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        sdp_reg[i] <= '0;
      end
      else if (wr_sdp[i])
      begin
        sdp_reg[i] <= bar_req.wdata[31:PTR_LSB];
      end
    end

    // engine advances the pointer only while enabled, so no write clash
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        ndp_reg[i] <= '0;
      end
      else if (wr_ndp[i] && !en_reg[i])
      begin
        ndp_reg[i] <= bar_req.wdata[31:PTR_LSB];
      end
      else if (state_reg[i] == ST_XFER && en_reg[i] && !rst_reg[i]
               && beats_left_reg[i] == '0)
      begin
        ndp_reg[i] <= pend_next_reg[i];
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        state_reg[i]      <= ST_IDLE;
        beats_left_reg[i] <= '0;
        pend_next_reg[i]  <= '0;
        pend_ioc_reg[i]   <= 1'b0;
      end
      else if (rst_reg[i])
      begin
        state_reg[i]      <= ST_IDLE;
        beats_left_reg[i] <= '0;
      end
      else
      begin
        case (state_reg[i])
          ST_IDLE, ST_WAIT:
          begin
            if (!en_reg[i])
            begin
              state_reg[i] <= ST_IDLE;
            end
            else if (ndp_reg[i] != sdp_reg[i])
            begin
              state_reg[i] <= ST_FETCH;
            end
            else
            begin
              state_reg[i] <= ST_WAIT;
            end
          end
          ST_FETCH:
          begin
            if (!en_reg[i])
            begin
              state_reg[i] <= ST_IDLE;
            end
            else if (fetch_done[i])
            begin
              if (fetch_resp[i].ok && fetch_ok_aligned)
              begin
                state_reg[i]      <= ST_XFER;
                beats_left_reg[i] <= fetch_resp[i].beats;
                pend_next_reg[i]  <= fetch_resp[i].next_ptr[31:PTR_LSB];
                pend_ioc_reg[i]   <= fetch_resp[i].ioc;
              end
              else
              begin
                state_reg[i] <= ST_IDLE;
              end
            end
          end
          ST_XFER:
          begin
            if (!en_reg[i] || beats_left_reg[i] == '0)
            begin
              state_reg[i] <= ST_IDLE;
            end
            else if (beat_seen[i])
            begin
              beats_left_reg[i] <= beats_left_reg[i] - 1'b1;
            end
          end
          default:
          begin
            state_reg[i] <= ST_IDLE;
          end
        endcase
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        accum_reg[i]  <= '0;
        bytes_reg[i]  <= '0;
        sample_reg[i] <= '0;
      end
      else if (sec_tick)
      begin
        bytes_reg[i]  <= accum_reg[i] + (30)'(beat_seen[i]);
        accum_reg[i]  <= '0;
        sample_reg[i] <= sample_reg[i] + 1'b1;
      end
      else if (beat_seen[i])
      begin
        accum_reg[i] <= accum_reg[i] + 1'b1;
      end
    end

    // checks that hold for every channel; faults are driven on channels 1 to 3
    property p_align_abort;
      @(posedge sys_clk) disable iff (!rst_n)
        (state_reg[i] == ST_FETCH && en_reg[i] && !rst_reg[i] && fetch_done[i]
         && fetch_resp[i].ok && !fetch_ok_aligned)
        |=> state_reg[i] == ST_IDLE && flag_reg[i][B_ALGN] && flag_reg[i][B_IACT];
    endproperty
    a_align_abort: assert property (p_align_abort) else $error("misaligned descriptor not aborted");

    property p_fetch_err;
      @(posedge sys_clk) disable iff (!rst_n)
        (state_reg[i] == ST_FETCH && en_reg[i] && !rst_reg[i] && fetch_done[i]
         && !fetch_resp[i].ok) |=> flag_reg[i][B_FERR] ##1 state_reg[i] != ST_XFER;
    endproperty
    a_fetch_err: assert property (p_fetch_err) else $error("fetch error not flagged");

    property p_sw_abort;
      @(posedge sys_clk) disable iff (!rst_n)
        ((state_reg[i] == ST_FETCH || state_reg[i] == ST_XFER) && !en_reg[i] && !rst_reg[i])
        |=> flag_reg[i][B_SWAB] && state_reg[i] == ST_IDLE;
    endproperty
    a_sw_abort: assert property (p_sw_abort) else $error("software abort not flagged");

    property p_rreq_ack;
      @(posedge sys_clk) disable iff (!rst_n)
        (rreq_reg[i] && reset_ack[i] && !wr_ctrl[i]) |=> !reset_request[i];
    endproperty
    a_rreq_ack: assert property (p_rreq_ack) else $error("reset request not cleared");

    property p_user_reset;
      @(posedge sys_clk) disable iff (!rst_n)
        rst_reg[i] |=> state_reg[i] == ST_IDLE && !ctrl_word[i][B_RUN];
    endproperty
    a_user_reset: assert property (p_user_reset) else $error("engine ran under reset");
  end

  // ------------------------------------------------------------
  // checks on channel 0
  // ------------------------------------------------------------
  property p_irq_gate;
    @(posedge sys_clk) disable iff (!rst_n)
      (wr_ctrl[0] && (!bar_req.wdata[B_IE] || bar_req.wdata[B_IACT]) && !flag_set[0][B_IACT])
      |=> !irq[0];
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable and active");

  property p_dcmp_sets;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_reg[0] == ST_XFER && en_reg[0] && !rst_reg[0] && beats_left_reg[0] == '0
       && pend_ioc_reg[0]) |=> flag_reg[0][B_DCMP] && flag_reg[0][B_IACT];
  endproperty
  a_dcmp_sets: assert property (p_dcmp_sets) else $error("completion flag not set");

  property p_start;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_reg[0] == ST_IDLE && en_reg[0] && !rst_reg[0] && ndp_reg[0] != sdp_reg[0])
      |=> fetch_req[0];
  endproperty
  a_start: assert property (p_start) else $error("engine did not start");

  property p_ndp_locked;
    @(posedge sys_clk) disable iff (!rst_n)
      (wr_ndp[0] && en_reg[0] && state_reg[0] != ST_XFER) |=> $stable(ndp_reg[0]);
  endproperty
  a_ndp_locked: assert property (p_ndp_locked) else $error("pointer written while enabled");

  property p_sample;
    @(posedge sys_clk) disable iff (!rst_n)
      sec_tick |=> sample_reg[0] == $past(sample_reg[0]) + 2'd1
                   && bytes_word[0][1:0] == sample_reg[0];
  endproperty
  a_sample: assert property (p_sample) else $error("sample count did not step");

  c_complete: cover property (@(posedge sys_clk) disable iff (!rst_n)
    flag_set[0][B_DCMP]);
  c_wait: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg[0] == ST_XFER ##[1:50] state_reg[0] == ST_WAIT);
  c_fifo_full: cover property (@(posedge sys_clk) disable iff (!rst_n)
    in_valid && !in_ready);
endmodule
`default_nettype wire

// *** rtl/sg_dma_pkg.sv ***
// shared constants and types for the scatter-gather channel register block
package sg_dma_pkg;

  localparam int NUM_CHAN = 4;
  localparam int CHAN_W   = 2;
  localparam int DATA_W   = 32;

  // ------------------------------------------------------------
  // address map (byte offsets from the first memory window)
  // ------------------------------------------------------------
  localparam logic [15:0] BASE_H2C0   = 16'h0000;
  localparam logic [15:0] BASE_H2C1   = 16'h0100;
  localparam logic [15:0] BASE_C2H0   = 16'h2000;
  localparam logic [15:0] BASE_C2H1   = 16'h2100;
  localparam logic [NUM_CHAN-1:0][15:0] CHAN_BASE = {BASE_C2H1, BASE_C2H0, BASE_H2C1, BASE_H2C0};
  localparam logic [15:0] COMMON_BASE = 16'h4000;
  localparam logic [15:0] PERF_BASE   = 16'h9000;
  localparam logic [15:0] APP0_BASE   = 16'h9100;
  localparam logic [15:0] APP1_BASE   = 16'h9200;
  localparam logic [15:0] PFIFO_BASE  = 16'h9300;

  localparam logic [7:0] OFF_CTRL  = 8'h04;
  localparam logic [7:0] OFF_NDP   = 8'h08;
  localparam logic [7:0] OFF_SDP   = 8'h0C;
  localparam logic [7:0] OFF_BYTES = 8'h1C;

  // ------------------------------------------------------------
  // engine control field positions
  // ------------------------------------------------------------
  localparam int B_IE   = 0;
  localparam int B_IACT = 1;
  localparam int B_DCMP = 2;
  localparam int B_ALGN = 3;
  localparam int B_FERR = 4;
  localparam int B_SWAB = 5;
  localparam int B_EN   = 8;
  localparam int B_RUN  = 10;
  localparam int B_WAIT = 11;
  localparam int B_RREQ = 14;
  localparam int B_RST  = 15;
  localparam int PTR_LSB = 5;
  localparam int CNT_LSB = 2;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;
  localparam int ONE_SEC_NS     = 1_000_000_000;
  localparam int ONE_SEC_CYCLES = ONE_SEC_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_XFER  = 4'b0100,
    ST_WAIT  = 4'b1000
  } eng_state_t;

  typedef enum logic [6:0] {
    RG_NONE   = 7'b000_0001,
    RG_CHAN   = 7'b000_0010,
    RG_COMMON = 7'b000_0100,
    RG_PERF   = 7'b000_1000,
    RG_APP0   = 7'b001_0000,
    RG_APP1   = 7'b010_0000,
    RG_PFIFO  = 7'b100_0000
  } region_t;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [31:0] wdata;
  } bar_req_t;

  typedef struct packed {
    logic        ok;
    logic        ioc;
    logic [31:0] next_ptr;
    logic [15:0] beats;
  } desc_resp_t;

  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [DATA_W-1:0] data;
  } beat_t;

endpackage

// *** rtl/stream_fifo.sv ***
// synchronous valid/ready fifo for the packet data path
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr_reg];

  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      // depth need not be a power of two
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/desc_mem_model.sv ***
// descriptor memory responder that answers the engines' fetch ports
`timescale 1ns/1ps
`default_nettype none
module desc_mem_model (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire logic [1:0]                  fault,
  input  wire logic [3:0]                  fetch_req,
  input  wire logic [3:0][31:0]            fetch_addr,
  output logic      [3:0]                  fetch_done,
  output sg_dma_pkg::desc_resp_t [3:0]     fetch_resp
);
  import sg_dma_pkg::*;
  logic [3:0][1:0] dly;
  // fault 1: failed completion, 2: unaligned link, 3: never answers
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      dly        <= '0;
      fetch_done <= '0;
      fetch_resp <= '0;
    end
    else
      for (int c = 0; c < 4; c++)
      begin
        dly[c]        <= (fetch_req[c] && !fetch_done[c]) ? dly[c] + 2'h1 : 2'h0;
        fetch_done[c] <= fetch_req[c] && dly[c] == 2'h2 && fault != 2'h3;
        // link to the next 32-byte slot, 36 bytes on under fault 2; stale data is inverted, not held
        fetch_resp[c] <= (dly[c] == 2'h2) ? {fault != 2'h1, 1'b1, fetch_addr[c] +
          ((fault == 2'h2) ? 32'h0000_0024 : 32'h0000_0020), 16'h0000} : ~fetch_resp[c];
      end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// self-checking bench for the channel register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sg_dma_pkg::*;
  logic             sys_clk = 0, rst_n = 0, bar_valid = 0, in_valid = 0, out_ready = 0;
  logic             bar_ready, bar_rvalid, in_ready, out_valid;
  bar_req_t         bar_req = '0;
  beat_t            in_beat = '0, out_beat;
  logic [3:0]       reset_ack = '0, fetch_done, fetch_req, irq, reset_request, user_reset;
  logic [3:0][31:0] fetch_addr;
  desc_resp_t [3:0] fetch_resp;
  logic [1:0]       fault = '0;
  logic [31:0]      bar_rdata, v, u, m, e;
  logic [15:0]      b;
  region_t          bar_region;
  int               failures = 0, n_tests = 0;
  always #50 sys_clk = ~sys_clk;
  sg_dma_channel_regs #(.SEC_CYCLES(64), .FIFO_DEPTH(8)) uut (.sys_clk, .rst_n, .bar_valid,
    .bar_req, .bar_ready, .bar_rvalid, .bar_rdata, .bar_region, .fetch_req, .fetch_addr,
    .fetch_done, .fetch_resp, .in_valid, .in_ready, .in_beat, .out_valid, .out_ready,
    .out_beat, .irq, .reset_request, .reset_ack, .user_reset);
  desc_mem_model mem (.sys_clk, .rst_n, .fault, .fetch_req, .fetch_addr, .fetch_done,
    .fetch_resp);
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    n_tests++;
    if (s !== x)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  // one access; read data lands in v
  task automatic acc(logic we, logic [15:0] a, logic [31:0] d);
    @(posedge sys_clk);
    bar_valid <= 1'b1;
    bar_req   <= {we, a, d};
    @(posedge sys_clk);
    bar_valid <= 1'b0;
    #1 v = bar_rdata;
    chk("bus answer", {bar_ready, bar_rvalid}, {1'b1, !we});
  endtask
  task automatic test_done;
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 3; r++)
      begin
        acc(0, CHAN_BASE[c] + 16'h0004 * (r + 1), 32'h0000_0000);
        chk("reset value", v, REG_RESET);
        chk("chan region", bar_region, RG_CHAN);
      end
    for (int i = 0; i < 5; i++)
    begin
      acc(0, (i == 0) ? 16'h4000 : 16'h8F00 + 16'h0100 * i, 32'h0000_0000);
      chk("region", bar_region, 7'h04 << i);
      chk("other read", v, 32'h0000_0000);
    end
    acc(0, 16'h5000, 32'h0000_0000);
    chk("unmapped", bar_region, RG_NONE);
    acc(1, 16'h0104, 32'h0000_C0F1);
    acc(0, 16'h0104, 32'h0000_0000);
    chk("ctrl", v, 32'h0000_C001);
    chk("reset lines", {reset_request[1], user_reset[1]}, 2'h3);
    reset_ack <= 4'h2;
    acc(0, 16'h0104, 32'h0000_0000);
    reset_ack <= 4'h0;
    chk("ack", v, 32'h0000_8001);
    acc(1, 16'h0104, 32'h0000_0000);
    acc(1, 16'h0008, 32'h0000_003F);
    acc(0, 16'h0008, 32'h0000_0000);
    chk("ndp", v, 32'h0000_0020);
    acc(1, 16'h000C, 32'h0000_007F);
    acc(0, 16'h000C, 32'h0000_0000);
    chk("sdp", v, 32'h0000_0060);
    acc(1, 16'h0004, 32'h0000_0101);
    for (int t = 0; t < 40 && !v[11]; t++)
      acc(0, 16'h0004, 32'h0000_0000);
    chk("chain done", v, 32'h0000_0907);
    chk("irq", irq, 4'h1);
    acc(1, 16'h0008, 32'h0000_0200);
    acc(0, 16'h0008, 32'h0000_0000);
    chk("ndp locked", v, 32'h0000_0060);
    acc(1, 16'h0004, 32'h0000_0100);
    acc(0, 16'h0004, 32'h0000_0000);
    chk("zero write", v, 32'h0000_0906);
    chk("irq off", irq, 4'h0);
    acc(1, 16'h0004, 32'h0000_0106);
    acc(0, 16'h0004, 32'h0000_0000);
    chk("w1c", v, 32'h0000_0900);
    for (int k = 1; k < 4; k++)
    begin
      b = (k == 3) ? 16'h0100 : 16'h1F00 + 16'h0100 * k;
      m = (k == 3) ? 32'h0000_013D : 32'h0000_013F;
      e = (k == 1) ? 32'h0000_0112 : (k == 2) ? 32'h0000_010A : 32'h0000_0020;
      fault <= k[1:0];
      acc(1, b + 16'h0008, 32'h0000_0020);
      acc(1, b + 16'h000C, 32'h0000_0040);
      acc(1, b + 16'h0004, 32'h0000_0100);
      for (int t = 0; t < 20 && k == 3 && !fetch_req[1]; t++)
        @(posedge sys_clk);
      if (k == 3)
      begin
        acc(0, b + 16'h0004, 32'h0000_0000);
        chk("running", v, 32'h0000_0500);
        acc(1, b + 16'h0004, 32'h0000_0000);
      end
      for (int t = 0; t < 30 && (v & m) != e; t++)
        acc(0, b + 16'h0004, 32'h0000_0000);
      chk("fault flags", v & m, e);
    end
    acc(0, 16'h001C, 32'h0000_0000);
    u = v;
    // poll until the next sample lands; reads are closer than one tick apart
    for (int t = 0; t < 40 && v[1:0] == u[1:0]; t++)
      acc(0, 16'h001C, 32'h0000_0000);
    chk("bytes", v, {30'h0, u[1:0] + 2'h1});
    // sink stalls while the buffer fills
    in_valid <= 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      in_beat <= {2'h3, 32'(i)};
      @(posedge sys_clk);
      #1 chk("in_ready", in_ready, i < 7);
    end
    in_valid  <= 1'b0;
    out_ready <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      chk("out", {out_valid, out_beat.chan, out_beat.data[28:0]}, {1'b1, 2'h3, 29'(i)});
      @(posedge sys_clk);
      #1;
    end
    chk("empty", out_valid, 1'b0);
    test_done();
  end
endmodule
`default_nettype wire
